// ---- rtl/tx_fifo.v ----
`timescale 1ns/100ps
// Small synchronous FIFO; read data leave through a register.
module tx_fifo #(
   parameter WIDTH = 9,
   parameter AW = 4,
   parameter DEPTH = 16
) (
   input wire clk,
   input wire rst_b,
   input wire [WIDTH-1:0] in_data,
   input wire in_valid,
   output wire in_ready,
   output reg [WIDTH-1:0] out_data,
   output reg out_valid,
   input wire out_ready
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0] wr_reg;
   reg [AW:0] rd_reg;
   wire [AW:0] fill;
   wire mem_empty;
   wire pull;
   assign fill = wr_reg - rd_reg;
   assign in_ready = (fill != DEPTH[AW:0]);
   assign mem_empty = (fill == {(AW+1){1'b0}});
   // The output register is a stage of its own and refills when drained.
   assign pull = !mem_empty && (!out_valid || out_ready);
   always @(posedge clk) begin
      if (in_valid && in_ready) begin
         mem[wr_reg[AW-1:0]] <= in_data;
      end
   end
   always @(posedge clk) begin
      if (!rst_b) begin
         wr_reg <= {(AW+1){1'b0}};
         rd_reg <= {(AW+1){1'b0}};
         out_valid <= 1'b0;
         out_data <= {WIDTH{1'b0}};
      end else begin
         if (in_valid && in_ready) begin
            wr_reg <= wr_reg + 1'b1;
         end
         if (pull) begin
            out_data <= mem[rd_reg[AW-1:0]];
            out_valid <= 1'b1;
            rd_reg <= rd_reg + 1'b1;
         end else if (out_ready) begin
            out_valid <= 1'b0;
         end
      end
   end
endmodule

// ---- rtl/uart_frame_defs.vh ----
`ifndef UART_FRAME_DEFS_VH
`define UART_FRAME_DEFS_VH
`define CSZ_5 3'h0
`define CSZ_6 3'h1
`define CSZ_7 3'h2
`define CSZ_8 3'h3
`define CSZ_9 3'h7
`define FIFO_W 9
`define FIFO_AW 4
`define FIFO_D 16
`define OVS_LAST 4'hF
`define OVS_MID 4'h7
`define BITCNT_W 4
`define ONE_BIT 4'h1
`endif

// ---- rtl/uart_frame_path.v ----
`timescale 1ns/100ps
`include "uart_frame_defs.vh"
module uart_frame_path (
   input wire mclk,
   input wire rst_b,
   input wire baud_tick,
   input wire sync_mode,
   input wire xfer_clock_pin,
   input wire [2:0] char_size_sel,
   input wire parity_enable_bit,
   input wire parity_odd,
   input wire two_stop,
   input wire tx_enable_bit,
   input wire rx_enable_bit,
   input wire tx_ninth_bit,
   input wire [7:0] tx_data,
   input wire tx_data_wr,
   output reg tx_data_ready,
   input wire tx_done_clr,
   input wire tx_done_irq_ack,
   input wire tx_buf_empty_irq_en,
   input wire tx_done_irq_en,
   input wire global_irq_en,
   output reg tx_buf_empty_flag,
   output reg tx_done_flag,
   output reg tx_buf_empty_irq,
   output reg tx_done_irq,
   input wire serial_in_pin,
   input wire port_in_value,
   output reg port_rx_value,
   output reg serial_out_pin,
   output reg serial_out_oe,
   input wire port_out_value,
   input wire port_out_oe,
   output reg [7:0] rx_data,
   output reg rx_ninth_bit,
   output reg rx_done_flag,
   input wire rx_data_rd
);
   ////////////////////////////////////////////////////////////////////////////
   localparam TX_IDLE = 3'h0;
   localparam TX_START = 3'h1;
   localparam TX_DATA = 3'h2;
   localparam TX_PAR = 3'h3;
   localparam TX_STOP = 3'h4;
   localparam RX_IDLE = 2'h0;
   localparam RX_START = 2'h1;
   localparam RX_DATA = 2'h2;
   localparam RX_STOP = 2'h3;

   function [3:0] data_bits;
      input [2:0] sel;
      begin
         case (sel)
            `CSZ_5: data_bits = 4'h5;
            `CSZ_6: data_bits = 4'h6;
            `CSZ_7: data_bits = 4'h7;
            `CSZ_9: data_bits = 4'h9;
            default: data_bits = 4'h8;
         endcase
      end
   endfunction

   function [8:0] data_mask;
      input [2:0] sel;
      begin
         case (sel)
            `CSZ_5: data_mask = 9'h01F;
            `CSZ_6: data_mask = 9'h03F;
            `CSZ_7: data_mask = 9'h07F;
            `CSZ_9: data_mask = 9'h1FF;
            default: data_mask = 9'h0FF;
         endcase
      end
   endfunction

   wire [3:0] nbits;
   wire [8:0] mask;
   assign nbits = data_bits(char_size_sel);
   assign mask = data_mask(char_size_sel);

   ////////////////////////////////////////////////////////////////////////////
   // Transmit buffer: the FIFO deepens the single buffer; empty flag tracks it.
   wire fifo_in_ready;
   wire [8:0] fifo_out;
   wire fifo_out_valid;
   wire load;
   wire wr_acc;
   wire [4:0] buf_cnt_next;
   reg [4:0] buf_cnt_reg;
   reg tx_on_reg;
   tx_fifo #(
      .WIDTH(`FIFO_W),
      .AW(`FIFO_AW),
      .DEPTH(`FIFO_D)
   ) u_fifo (
      .clk(mclk),
      .rst_b(rst_b),
      .in_data({tx_ninth_bit, tx_data}),
      .in_valid(tx_data_wr),
      .in_ready(fifo_in_ready),
      .out_data(fifo_out),
      .out_valid(fifo_out_valid),
      .out_ready(load)
   );

   reg [2:0] tx_st_reg;
   reg [8:0] tx_sh_reg;
   reg [3:0] tx_cnt_reg;
   reg tx_par_reg;
   reg tx_second_reg;
   reg tx_active_reg;
   reg xck_d_reg;
   wire tx_tick;
   wire last_stop;

   // In synchronous mode both directions step on the transfer clock rising edge.
   assign tx_tick = sync_mode ? (xfer_clock_pin && !xck_d_reg) : baud_tick;
   assign last_stop = (tx_st_reg == TX_STOP) && tx_tick && (tx_second_reg || !two_stop);
   // A cleared enable keeps the shifter running until nothing is left to send.
   assign load = (tx_enable_bit || tx_on_reg) && fifo_out_valid &&
                 ((tx_st_reg == TX_IDLE) || last_stop);
   // Words held anywhere in the buffer, FIFO memory and output stage alike.
   assign wr_acc = tx_data_wr && fifo_in_ready;
   assign buf_cnt_next = buf_cnt_reg + {4'h0, wr_acc} - {4'h0, load};

   always @(posedge mclk) begin
      if (!rst_b) begin
         tx_st_reg <= TX_IDLE;
         tx_sh_reg <= 9'h000;
         tx_cnt_reg <= 4'h0;
         tx_par_reg <= 1'b0;
         tx_second_reg <= 1'b0;
         tx_active_reg <= 1'b0;
         xck_d_reg <= 1'b0;
         serial_out_pin <= 1'b1;
         serial_out_oe <= 1'b0;
         tx_done_flag <= 1'b0;
         tx_buf_empty_flag <= 1'b1;
         tx_data_ready <= 1'b0;
         tx_buf_empty_irq <= 1'b0;
         tx_done_irq <= 1'b0;
         buf_cnt_reg <= 5'h00;
         tx_on_reg <= 1'b0;
      end else begin
         xck_d_reg <= xfer_clock_pin;
         buf_cnt_reg <= buf_cnt_next;
         tx_on_reg <= tx_enable_bit ||
                      (tx_on_reg && (tx_active_reg || (buf_cnt_reg != 5'h00)));
         if (load) begin
            tx_st_reg <= TX_START;
            tx_sh_reg <= fifo_out & mask;
            tx_par_reg <= ^(fifo_out & mask) ^ parity_odd;
            tx_cnt_reg <= 4'h0;
            tx_second_reg <= 1'b0;
            tx_active_reg <= 1'b1;
            serial_out_pin <= 1'b0;
         end else if (tx_tick) begin
            case (tx_st_reg)
               TX_START: begin
                  tx_st_reg <= TX_DATA;
                  serial_out_pin <= tx_sh_reg[0];
                  tx_sh_reg <= {1'b0, tx_sh_reg[8:1]};
                  tx_cnt_reg <= `ONE_BIT;
               end
               TX_DATA: begin
                  if (tx_cnt_reg == nbits) begin
                     if (parity_enable_bit) begin
                        tx_st_reg <= TX_PAR;
                        serial_out_pin <= tx_par_reg;
                     end else begin
                        tx_st_reg <= TX_STOP;
                        serial_out_pin <= 1'b1;
                     end
                  end else begin
                     serial_out_pin <= tx_sh_reg[0];
                     tx_sh_reg <= {1'b0, tx_sh_reg[8:1]};
                     tx_cnt_reg <= tx_cnt_reg + 1'b1;
                  end
               end
               TX_PAR: begin
                  tx_st_reg <= TX_STOP;
                  serial_out_pin <= 1'b1;
               end
               TX_STOP: begin
                  if (tx_second_reg || !two_stop) begin
                     tx_st_reg <= TX_IDLE;
                     tx_active_reg <= 1'b0;
                  end else begin
                     tx_second_reg <= 1'b1;
                  end
               end
               default: tx_st_reg <= TX_IDLE;
            endcase
         end
         // Pin is released only once nothing is left to send.
         if (tx_enable_bit || tx_on_reg || tx_active_reg || (buf_cnt_reg != 5'h00)) begin
            serial_out_oe <= 1'b1;
         end else begin
            serial_out_oe <= port_out_oe;
            serial_out_pin <= port_out_value;
         end
         // Set wins over the clear when both arrive together.
         if (last_stop && !load && (buf_cnt_reg == 5'h00) && !tx_data_wr) begin
            tx_done_flag <= 1'b1;
         end else if (tx_done_clr || tx_done_irq_ack) begin
            tx_done_flag <= 1'b0;
         end
         tx_buf_empty_flag <= (buf_cnt_next == 5'h00) && !tx_data_wr;
         tx_data_ready <= fifo_in_ready;
         tx_buf_empty_irq <= tx_buf_empty_flag && tx_buf_empty_irq_en && global_irq_en;
         tx_done_irq <= tx_done_flag && tx_done_irq_en && global_irq_en;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receiver: 16x oversampling in asynchronous mode, transfer clock otherwise.
   reg [1:0] rx_st_reg;
   reg [3:0] ovs_reg;
   reg [3:0] rx_cnt_reg;
   reg [8:0] rx_sh_reg;
   wire rx_in;
   wire rx_sample;

   assign rx_in = rx_enable_bit ? serial_in_pin : 1'b1;
   assign rx_sample = sync_mode ? tx_tick : (baud_tick && (ovs_reg == `OVS_MID));

   always @(posedge mclk) begin
      if (!rst_b) begin
         rx_st_reg <= RX_IDLE;
         ovs_reg <= 4'h0;
         rx_cnt_reg <= 4'h0;
         rx_sh_reg <= 9'h000;
         rx_data <= 8'h00;
         rx_ninth_bit <= 1'b0;
         rx_done_flag <= 1'b0;
         port_rx_value <= 1'b1;
      end else begin
         port_rx_value <= rx_enable_bit ? 1'b1 : port_in_value;
         if (baud_tick) begin
            ovs_reg <= ovs_reg + 1'b1;
         end
         if (!rx_enable_bit) begin
            rx_st_reg <= RX_IDLE;
            rx_done_flag <= 1'b0;
         end else begin
            case (rx_st_reg)
               RX_IDLE: begin
                  if (!rx_in) begin
                     rx_st_reg <= RX_START;
                     ovs_reg <= 4'h0;
                  end
               end
               RX_START: begin
                  if (rx_sample) begin
                     if (!rx_in) begin
                        rx_st_reg <= RX_DATA;
                        rx_cnt_reg <= 4'h0;
                        rx_sh_reg <= 9'h000;
                     end else begin
                        rx_st_reg <= RX_IDLE;
                     end
                  end
               end
               RX_DATA: begin
                  if (rx_sample) begin
                     // Without parity the next sample must already be the stop bit.
                     if (rx_cnt_reg < nbits) begin
                        rx_sh_reg[rx_cnt_reg] <= rx_in;
                        rx_cnt_reg <= rx_cnt_reg + 1'b1;
                        if (((rx_cnt_reg + `ONE_BIT) == nbits) && !parity_enable_bit) begin
                           rx_st_reg <= RX_STOP;
                        end
                     end else begin
                        rx_cnt_reg <= rx_cnt_reg + 1'b1;
                        rx_st_reg <= RX_STOP;
                     end
                  end
               end
               RX_STOP: begin
                  if (rx_sample) begin
                     rx_st_reg <= RX_IDLE;
                     rx_data <= rx_sh_reg[7:0] & mask[7:0];
                     rx_ninth_bit <= rx_sh_reg[8] & mask[8];
                     rx_done_flag <= 1'b1;
                  end
               end
               default: rx_st_reg <= RX_IDLE;
            endcase
            if (rx_data_rd && !(rx_st_reg == RX_STOP && rx_sample)) begin
               rx_done_flag <= 1'b0;
            end
         end
      end
   end
endmodule

// ---- verification/uart_frame_path_sva.sv ----
`timescale 1ns/100ps
`include "uart_frame_defs.vh"
module uart_frame_path_sva (
   input wire mclk, rst_b, tx_enable_bit, rx_enable_bit,
   input wire [2:0] char_size_sel,
   input wire tx_data_wr, tx_data_ready, tx_done_clr, tx_done_irq_ack,
   input wire tx_buf_empty_irq_en, tx_done_irq_en, global_irq_en,
   input wire tx_buf_empty_flag, tx_done_flag, tx_buf_empty_irq, tx_done_irq,
   input wire serial_out_pin, serial_out_oe, rx_done_flag,
   input wire [7:0] rx_data
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   a_wr_clears_empty: assert property (
      tx_data_wr && tx_data_ready |=> !tx_buf_empty_flag) else $error("empty flag kept");
   a_empty_irq_on: assert property (
      tx_buf_empty_flag && tx_buf_empty_irq_en && global_irq_en |=> tx_buf_empty_irq)
      else $error("empty irq missing");
   a_done_irq_on: assert property (
      $rose(tx_done_flag) && tx_done_irq_en && global_irq_en |=> tx_done_irq)
      else $error("done irq missing");
   a_done_flag_clear: assert property (
      tx_done_flag && (tx_done_clr || tx_done_irq_ack) && tx_buf_empty_flag && !tx_data_wr
      |=> !tx_done_flag) else $error("done flag not cleared");
   a_idle_start_soon: assert property (
      tx_enable_bit && tx_done_flag && tx_buf_empty_flag && tx_data_wr && tx_data_ready
      |-> ##[2:3] !serial_out_pin) else $error("start bit late");
   a_pending_keeps_pin: assert property (
      !tx_buf_empty_flag && $past(!tx_buf_empty_flag) |-> serial_out_oe)
      else $error("pin released early");
   a_rx_off_flush: assert property (
      !rx_enable_bit |=> !rx_done_flag) else $error("receive flag kept");
   a_rx_short_mask: assert property (
      rx_done_flag && char_size_sel == `CSZ_5 |-> rx_data[7:5] == 3'h0)
      else $error("upper bits set");
   c_done_irq: cover property (tx_done_irq);
   c_fifo_full: cover property (!tx_data_ready);
   c_rx_byte: cover property (rx_done_flag);
endmodule
bind uart_frame_path uart_frame_path_sva chk (.*);

// ---- verification/uart_frame_path_tb.sv ----
`timescale 1ns/100ps
`include "uart_frame_defs.vh"
module uart_frame_path_tb;
   reg mclk = 1'h0;
   reg rst_b = 1'h0;
   reg [2:0] csz = `CSZ_8;
   reg pen = 1'h0, podd = 1'h0, two = 1'h0, ten = 1'h0, ren = 1'h0, nin = 1'h0, wr = 1'h0;
   reg dclr = 1'h0, dack = 1'h0, bie = 1'h0, die = 1'h0, gie = 1'h0, rd = 1'h0, ok;
   reg pov = 1'h1, poe = 1'h0, piv = 1'h1;
   reg [7:0] txd = 8'h00;
   reg [8:0] d;
   reg [11:0] got;
   wire rdy, bef, tdf, bei, tdi, prv, sop, soe, rxn, rdf, sin;
   wire [7:0] rxd;
   integer err_total = 0, n_checks = 0, fn, i, k;
   always #2.5 mclk = ~mclk;
   uart_frame_path dut (.mclk(mclk), .rst_b(rst_b), .baud_tick(1'h1), .sync_mode(1'h0),
      .xfer_clock_pin(1'h0), .char_size_sel(csz), .parity_enable_bit(pen), .parity_odd(podd),
      .two_stop(two), .tx_enable_bit(ten), .rx_enable_bit(ren), .tx_ninth_bit(nin),
      .tx_data(txd), .tx_data_wr(wr), .tx_data_ready(rdy), .tx_done_clr(dclr),
      .tx_done_irq_ack(dack), .tx_buf_empty_irq_en(bie), .tx_done_irq_en(die),
      .global_irq_en(gie), .tx_buf_empty_flag(bef), .tx_done_flag(tdf),
      .tx_buf_empty_irq(bei), .tx_done_irq(tdi), .serial_in_pin(sin), .port_in_value(piv),
      .port_rx_value(prv), .serial_out_pin(sop), .serial_out_oe(soe), .port_out_value(pov),
      .port_out_oe(poe), .rx_data(rxd), .rx_ninth_bit(rxn), .rx_done_flag(rdf),
      .rx_data_rd(rd));
   uart_line_partner peer (.mclk(mclk), .serial_out_pin(sop), .line_out(sin));
   ////////////////////////////////////////////////////////////
   task tick(input integer n);
      begin
         repeat (n) @(posedge mclk);
         #1;
      end
   endtask
   task chk(input [11:0] g, input [11:0] e, input [79:0] what);
      begin
         n_checks = n_checks + 1;
         if (g !== e) begin
            err_total = err_total + 1;
            $display("Error %0t: %0s got %h want %h", $time, what, g, e);
         end
      end
   endtask
   task report_and_stop;
      begin
         $display("checks %0d mismatches %0d", n_checks, err_total);
         if (err_total == 0 && n_checks > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   function cond(input integer s);
      case (s)
         2: cond = tdf === 1'h1;
         3: cond = rdf === 1'h1;
         default: cond = soe === 1'h0;
      endcase
   endfunction
   task await(input integer s);
      begin
         i = 0;
         while (!cond(s) && i < 6000) begin
            tick(1);
            i = i + 1;
         end
         if (!cond(s)) begin
            err_total = err_total + 1;
            $display("Error %0t: wait %0d timed out", $time, s);
            report_and_stop;
         end
      end
   endtask
   function integer nbits(input [2:0] c);
      nbits = (c == `CSZ_9) ? 9 : c + 5;
   endfunction
   // Data bits, parity and stop bits of one frame, first bit at index 0.
   function [11:0] fr(input [8:0] v);
      integer j;
      begin
         fr = 12'hFFF;
         for (j = 0; j < nbits(csz); j = j + 1)
            fr[j] = v[j];
         if (pen)
            fr[nbits(csz)] = ^(v & ((9'h001 << nbits(csz)) - 9'h001)) ^ podd;
      end
   endfunction
   ////////////////////////////////////////////////////////////
   initial begin
      tick(5);
      rst_b = 1'h1;
      chk({sop, soe, bef, tdf, rdf}, 12'h014, "reset");
      {ten, die, gie} = 3'h7;
      for (k = 0; k < 5; k = k + 1) begin
         csz = (k == 4) ? `CSZ_9 : k[2:0];
         pen = k != 0 && k != 2;
         podd = k > 2;
         two = k > 1;
         d = 9'h0B5 + k[8:0] * 9'h062;
         tick(2);
         {nin, txd} = d;
         wr = 1'h1;
         tick(1);
         wr = 1'h0;
         chk(bef, 1'h0, "empty");
         fn = nbits(csz) + pen + 1 + two;
         peer.grab(fn, got, ok);
         chk(ok, 1'h1, "start");
         chk(got, fr(d) & ((12'h001 << fn) - 12'h001), "frame");
         await(2);
         tick(1);
         chk(tdi, 1'h1, "done irq");
         if (k < 4) begin
            {dclr, dack} = {!k[0], k[0]};
            tick(1);
            {dclr, dack} = 2'h0;
            tick(1);
            chk(tdf, 1'h0, "done clr");
         end
      end
      $display("test tx frames ended");
      csz = `CSZ_5;
      {pen, two, bie} = 3'h1;
      ten = 1'h0;
      k = 0;
      wr = 1'h1;
      while (rdy === 1'h1 && k < 40) begin
         txd = k[7:0];
         tick(1);
         k = k + 1;
      end
      wr = 1'h0;
      chk(k >= 16 && k <= 18, 1'h1, "depth");
      chk(bei, 1'h0, "irq full");
      ten = 1'h1;
      tick(1);
      ten = 1'h0;
      tick(2);
      chk(soe, 1'h1, "held");
      await(4);
      chk({bef, tdf}, 12'h003, "drained");
      {pov, poe} = 2'h1;
      tick(2);
      chk({sop, soe}, 12'h001, "port");
      chk(bei, 1'h1, "irq empty");
      bie = 1'h0;
      tick(2);
      chk(bei, 1'h0, "irq mask");
      $display("test tx buffer ended");
      ren = 1'h1;
      {pen, two} = 2'h3;
      tick(2);
      chk(prv, 1'h1, "rx port");
      d = 9'h1F5;
      peer.send({fr(d), 1'h0}, nbits(csz) + 4);
      await(3);
      chk(rxd, 8'h15, "short");
      rd = 1'h1;
      tick(1);
      rd = 1'h0;
      tick(1);
      chk(rdf, 1'h0, "read");
      csz = `CSZ_9;
      d = 9'h1C3;
      peer.send({fr(d), 1'h0}, nbits(csz) + 4);
      await(3);
      chk({rxn, rxd}, 12'h1C3, "nine");
      ren = 1'h0;
      tick(2);
      chk(rdf, 1'h0, "flush");
      $display("test rx ended");
      report_and_stop;
   end
endmodule

// ---- verification/uart_line_partner.sv ----
`timescale 1ns/100ps
module uart_line_partner (
   input wire mclk,
   input wire serial_out_pin,
   output reg line_out
);
   initial line_out = 1'h1;
   ////////////////////////////////////////////////////////////
   // Bits last 16 baud ticks; the bench raises baud_tick every cycle.
   task send(input [12:0] bits, input integer n);
      integer i;
      begin
         for (i = 0; i < n; i = i + 1) begin
            line_out <= bits[i];
            repeat (16) @(posedge mclk);
         end
         line_out <= 1'h1;
         #1;
      end
   endtask
   // The start bit gives the bit period, so data bit 0 must be high.
   task grab(input integer n, output [11:0] cap, output okay);
      integer i, p;
      begin
         cap = 12'h000;
         p = 0;
         while (serial_out_pin !== 1'h0 && p < 99) begin
            @(posedge mclk);
            p = p + 1;
         end
         p = 0;
         while (serial_out_pin === 1'h0 && p < 99) begin
            @(posedge mclk);
            p = p + 1;
         end
         okay = p > 0 && p < 99;
         for (i = 0; i < n; i = i + 1) begin
            repeat (p / 2) @(posedge mclk);
            cap[i] = serial_out_pin;
            repeat (p - p / 2) @(posedge mclk);
         end
         #1;
      end
   endtask
endmodule
